// ===== logic/profile_bank.sv
// Profile configuration bank: profile 2 dividers and lock detectors, profile 3 priorities and period
// Notes on behaviour
// R1 - Input divider is 30 bits over four bytes; ratio is value plus one.
// R2 - Integer feedback divider is 20 bits over three bytes; ratio is value plus one.
// R3 - Software never writes an integer feedback value below seven.
// R4 - Fraction numerator and modulus are 10 bits each, split across three bytes.
// R5 - Phase lock threshold is 16 bits; its unit comes from the priority scale bit.
// R6 - Scale bit zero means picoseconds, one means nanoseconds.
// R7 - Each profile has its own 8-bit phase lock fill and drain rates.
// R8 - Frequency lock threshold is 24 bits in picoseconds over three bytes.
// R9 - Each profile has its own 8-bit frequency lock fill and drain rates.
// R10 - A 3-bit selection priority, zero to seven, ranks the reference.
// R11 - A separate 3-bit promoted priority applies while the reference is active.
// R12 - Software keeps promoted priority no greater than selection priority.
// R13 - Nominal reference period is 40 bits in femtoseconds, low byte first.
// R14 - Software writes zeros to the two pad bytes after the period.
// R15 - Each profile's fields are stored apart; writes never touch another profile.
module profile_bank
  import profile_bank_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  input wire logic REF_ACTIVE,
  input wire logic P2_PH_SCALE,
  output logic [DATA_W-1:0] RDATA,
  output freq_cfg_t FREQ_CFG,
  output ref_cfg_t REF_CFG,
  output logic FB_INT_LOW
);

  reg_req_t req;
  logic [IN_DIV_W-1:0] in_div_reg;
  logic [FB_INT_W-1:0] fb_int_reg;
  logic [FRAC_W-1:0] fb_num_reg;
  logic [FRAC_W-1:0] fb_mod_reg;
  logic [PH_THR_W-1:0] ph_thr_reg;
  logic [7:0] ph_fill_reg;
  logic [7:0] ph_drain_reg;
  logic [FR_THR_W-1:0] fr_thr_reg;
  logic [7:0] fr_fill_reg;
  logic [7:0] fr_drain_reg;
  logic scale_reg;
  logic [PRIO_W-1:0] promo_reg;
  logic [PRIO_W-1:0] sel_reg;
  logic [PERIOD_W-1:0] period_reg;
  logic [15:0] pad_reg;
  logic [DATA_W-1:0] rdata_next;
  logic [DATA_W-1:0] rdata_reg;
  logic ref_active_reg;

  // Byte index of an address inside a multi-byte field, or all ones when outside
  function automatic logic [2:0] byte_of(input logic [15:0] a, input logic [15:0] base, input int n);
    logic [15:0] d;
    d = a - base;
    if (a >= base && d < 16'(n)) begin
      return d[2:0];
    end
    return 3'b111;
  endfunction

  assign req = '{addr: ADDR, wdata: WDATA, wr: WR_STB, rd: RD_STB};

  // Input divider, four bytes, top two bits of the last byte unused
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      in_div_reg <= '0;
    end else if (req.wr) begin
      case (byte_of(req.addr, IN_DIV_ADDR, 4))
        3'd0: in_div_reg[7:0] <= req.wdata; // [R1]
        3'd1: in_div_reg[15:8] <= req.wdata; // [R1]
        3'd2: in_div_reg[23:16] <= req.wdata; // [R1]
        3'd3: in_div_reg[29:24] <= req.wdata[IN_DIV_TOP_W-1:0]; // [R1]
        default: ;
      endcase
    end
  end

  // Integer feedback divider; fourth byte is unused and not stored
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      fb_int_reg <= '0;
    end else if (req.wr) begin
      case (byte_of(req.addr, FB_INT_ADDR, 3))
        3'd0: fb_int_reg[7:0] <= req.wdata; // [R2]
        3'd1: fb_int_reg[15:8] <= req.wdata; // [R2]
        3'd2: fb_int_reg[19:16] <= req.wdata[FB_INT_TOP_W-1:0]; // [R2]
        default: ;
      endcase
    end
  end

  // Fractional feedback: numerator and modulus interleaved across three bytes
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      fb_num_reg <= '0;
      fb_mod_reg <= '0;
    end else if (req.wr) begin
      case (byte_of(req.addr, FB_FRAC_ADDR, 3))
        3'd0: fb_num_reg[7:0] <= req.wdata; // [R4]
        3'd1: begin
          fb_num_reg[9:8] <= req.wdata[NUM_HI_W-1:0]; // [R4]
          fb_mod_reg[3:0] <= req.wdata[7:MOD_LO_POS]; // [R4]
        end
        3'd2: fb_mod_reg[9:4] <= req.wdata[MOD_HI_W-1:0]; // [R4]
        default: ;
      endcase
    end
  end

  // Phase lock detector settings of profile 2
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ph_thr_reg <= '0;
      ph_fill_reg <= BYTE_RST;
      ph_drain_reg <= BYTE_RST;
    end else if (req.wr) begin
      if (req.addr == PH_THR_ADDR) begin
        ph_thr_reg[7:0] <= req.wdata; // [R5]
      end else if (req.addr == PH_THR_ADDR + 16'h0001) begin
        ph_thr_reg[15:8] <= req.wdata; // [R5]
      end else if (req.addr == PH_FILL_ADDR) begin
        ph_fill_reg <= req.wdata; // [R7]
      end else if (req.addr == PH_DRAIN_ADDR) begin
        ph_drain_reg <= req.wdata; // [R7]
      end
    end
  end

  // Frequency lock detector settings of profile 2
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      fr_thr_reg <= '0;
      fr_fill_reg <= BYTE_RST;
      fr_drain_reg <= BYTE_RST;
    end else if (req.wr) begin
      case (byte_of(req.addr, FR_THR_ADDR, 3))
        3'd0: fr_thr_reg[7:0] <= req.wdata; // [R8]
        3'd1: fr_thr_reg[15:8] <= req.wdata; // [R8]
        3'd2: fr_thr_reg[23:16] <= req.wdata; // [R8]
        default: begin
          if (req.addr == FR_FILL_ADDR) begin
            fr_fill_reg <= req.wdata; // [R9]
          end else if (req.addr == FR_DRAIN_ADDR) begin
            fr_drain_reg <= req.wdata; // [R9]
          end
        end
      endcase
    end
  end

  // Profile 3 priorities; bit 6 is unused and not stored
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      scale_reg <= 1'b0;
      promo_reg <= '0;
      sel_reg <= '0;
    end else if (req.wr && req.addr == PRIO_ADDR) begin // [R15]
      scale_reg <= req.wdata[SCALE_POS]; // [R6]
      promo_reg <= req.wdata[PROMO_POS +: PRIO_W]; // [R11]
      sel_reg <= req.wdata[SEL_POS +: PRIO_W]; // [R10]
    end
  end

  // Profile 3 nominal period, low byte first, plus the two pad bytes
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      period_reg <= '0;
      pad_reg <= '0;
    end else if (req.wr) begin
      case (byte_of(req.addr, PERIOD_ADDR, 7))
        3'd0: period_reg[7:0] <= req.wdata; // [R13]
        3'd1: period_reg[15:8] <= req.wdata; // [R13]
        3'd2: period_reg[23:16] <= req.wdata; // [R13]
        3'd3: period_reg[31:24] <= req.wdata; // [R13]
        3'd4: period_reg[39:32] <= req.wdata; // [R13]
        3'd5: pad_reg[7:0] <= req.wdata; // Kept so software can read back what it wrote
        3'd6: pad_reg[15:8] <= req.wdata;
        default: ;
      endcase
    end
  end

  // Read mux; unused bits and unmapped addresses read as zero
  always_comb begin
    rdata_next = '0;
    if (req.addr >= IN_DIV_ADDR && req.addr <= LAST_ADDR) begin
      case (req.addr - IN_DIV_ADDR)
        16'h0000: rdata_next = in_div_reg[7:0];
        16'h0001: rdata_next = in_div_reg[15:8];
        16'h0002: rdata_next = in_div_reg[23:16];
        16'h0003: rdata_next = {2'b00, in_div_reg[29:24]};
        16'h0004: rdata_next = fb_int_reg[7:0];
        16'h0005: rdata_next = fb_int_reg[15:8];
        16'h0006: rdata_next = {4'h0, fb_int_reg[19:16]};
        16'h0008: rdata_next = fb_num_reg[7:0];
        16'h0009: rdata_next = {fb_mod_reg[3:0], 2'b00, fb_num_reg[9:8]};
        16'h000a: rdata_next = {2'b00, fb_mod_reg[9:4]};
        16'h000b: rdata_next = ph_thr_reg[7:0];
        16'h000c: rdata_next = ph_thr_reg[15:8];
        16'h000d: rdata_next = ph_fill_reg;
        16'h000e: rdata_next = ph_drain_reg;
        16'h000f: rdata_next = fr_thr_reg[7:0];
        16'h0010: rdata_next = fr_thr_reg[15:8];
        16'h0011: rdata_next = fr_thr_reg[23:16];
        16'h0012: rdata_next = fr_fill_reg;
        16'h0013: rdata_next = fr_drain_reg;
        16'h0014: rdata_next = {scale_reg, 1'b0, promo_reg, sel_reg};
        16'h0015: rdata_next = period_reg[7:0];
        16'h0016: rdata_next = period_reg[15:8];
        16'h0017: rdata_next = period_reg[23:16];
        16'h0018: rdata_next = period_reg[31:24];
        16'h0019: rdata_next = period_reg[39:32];
        16'h001a: rdata_next = pad_reg[7:0];
        16'h001b: rdata_next = pad_reg[15:8];
        default: rdata_next = '0;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rdata_reg <= '0;
    end else if (req.rd) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= '0;
    end
  end

  // Active-reference flag registered so the effective priority is glitch free
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ref_active_reg <= 1'b0;
    end else begin
      ref_active_reg <= REF_ACTIVE;
    end
  end

  assign RDATA = rdata_reg;

  // Decoded settings; ratios carry the extra bit so the plus one cannot wrap
  assign FREQ_CFG.in_div_ratio = {1'b0, in_div_reg} + 31'd1; // [R1]
  assign FREQ_CFG.fb_int_ratio = {1'b0, fb_int_reg} + 21'd1; // [R2]
  assign FREQ_CFG.fb_num = fb_num_reg;
  assign FREQ_CFG.fb_mod = fb_mod_reg;
  assign FREQ_CFG.ph_thr = ph_thr_reg;
  // Profile 2's scale bit sits in its own priority register outside this bank and arrives as a level;
  // tying it to profile 3's bit would let one profile's write change the other's unit
  assign FREQ_CFG.ph_unit = P2_PH_SCALE ? UNIT_NS : UNIT_PS; // [R5] [R6]
  assign FREQ_CFG.ph_fill = ph_fill_reg;
  assign FREQ_CFG.ph_drain = ph_drain_reg;
  assign FREQ_CFG.fr_thr = fr_thr_reg;
  assign FREQ_CFG.fr_fill = fr_fill_reg;
  assign FREQ_CFG.fr_drain = fr_drain_reg;

  assign REF_CFG.sel_prio = sel_reg;
  assign REF_CFG.promo_prio = promo_reg;
  assign REF_CFG.eff_prio = ref_active_reg ? promo_reg : sel_reg; // [R11]
  assign REF_CFG.ph_unit = scale_reg ? UNIT_NS : UNIT_PS; // [R6]
  assign REF_CFG.period_fs = period_reg;

  // Status only: flags a value software was not meant to program
  assign FB_INT_LOW = (fb_int_reg < FB_INT_MIN); // [R3]

endmodule

// ===== logic/profile_bank_pkg.sv
// Package: byte addresses, field layouts and reset values of the profile configuration bank
package profile_bank_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // Byte addresses, profile 2 frequency multiplication and lock detectors
  localparam logic [15:0] IN_DIV_ADDR = 16'h069e;
  localparam logic [15:0] FB_INT_ADDR = 16'h06a2;
  localparam logic [15:0] FB_FRAC_ADDR = 16'h06a6;
  localparam logic [15:0] PH_THR_ADDR = 16'h06a9;
  localparam logic [15:0] PH_FILL_ADDR = 16'h06ab;
  localparam logic [15:0] PH_DRAIN_ADDR = 16'h06ac;
  localparam logic [15:0] FR_THR_ADDR = 16'h06ad;
  localparam logic [15:0] FR_FILL_ADDR = 16'h06b0;
  localparam logic [15:0] FR_DRAIN_ADDR = 16'h06b1;
  // Byte addresses, profile 3 priorities and period
  localparam logic [15:0] PRIO_ADDR = 16'h06b2;
  localparam logic [15:0] PERIOD_ADDR = 16'h06b3;
  localparam logic [15:0] PAD_ADDR = 16'h06b8;
  localparam logic [15:0] LAST_ADDR = 16'h06b9;

  // Field widths
  localparam int IN_DIV_W = 30;
  localparam int FB_INT_W = 20;
  localparam int FRAC_W = 10;
  localparam int PH_THR_W = 16;
  localparam int FR_THR_W = 24;
  localparam int PERIOD_W = 40;
  localparam int PRIO_W = 3;

  // Field positions inside their bytes
  localparam int IN_DIV_TOP_W = 6;    // Byte 3 bits 5:0
  localparam int FB_INT_TOP_W = 4;    // Byte 2 bits 3:0
  localparam int NUM_HI_W = 2;        // Frac byte 1 bits 1:0
  localparam int MOD_LO_POS = 4;      // Frac byte 1 bits 7:4
  localparam int MOD_HI_W = 6;        // Frac byte 2 bits 5:0
  localparam int SCALE_POS = 7;
  localparam int PROMO_POS = 3;
  localparam int SEL_POS = 0;

  // Reset values
  localparam logic [7:0] BYTE_RST = 8'h00;

  // Least legal integer feedback value, checked by software
  localparam logic [19:0] FB_INT_MIN = 20'h0_0007;

  // Phase lock threshold unit
  typedef enum logic {
    UNIT_PS = 1'b0,
    UNIT_NS = 1'b1
  } lock_unit_t;

  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // Decoded settings handed to the PLL datapath
  typedef struct packed {
    logic [IN_DIV_W:0] in_div_ratio;
    logic [FB_INT_W:0] fb_int_ratio;
    logic [FRAC_W-1:0] fb_num;
    logic [FRAC_W-1:0] fb_mod;
    logic [PH_THR_W-1:0] ph_thr;
    lock_unit_t ph_unit;
    logic [7:0] ph_fill;
    logic [7:0] ph_drain;
    logic [FR_THR_W-1:0] fr_thr;
    logic [7:0] fr_fill;
    logic [7:0] fr_drain;
  } freq_cfg_t;

  typedef struct packed {
    logic [PRIO_W-1:0] sel_prio;
    logic [PRIO_W-1:0] promo_prio;
    logic [PRIO_W-1:0] eff_prio;
    lock_unit_t ph_unit;
    logic [PERIOD_W-1:0] period_fs;
  } ref_cfg_t;

endpackage

// ===== tb/profile_bank_assertions.sv
// Checker: port-level properties of the profile configuration bank
module profile_bank_assertions
  import profile_bank_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  input wire logic REF_ACTIVE,
  input wire logic P2_PH_SCALE,
  input wire logic [DATA_W-1:0] RDATA,
  input wire freq_cfg_t FREQ_CFG,
  input wire ref_cfg_t REF_CFG,
  input wire logic FB_INT_LOW
);
  // Single clock domain, so one clocking and one disable serve all
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);

  // Write effects and readback tied to the causing strobe, plus flag, unit and active-priority checks
  a_in_div_plus1: assert property (WR_STB && ADDR == IN_DIV_ADDR
    |=> FREQ_CFG.in_div_ratio[7:0] == 8'($past(WDATA) + 8'h01)) else $error("divider ratio wrong");
  a_fb_int_floor: assert property (FB_INT_LOW == (FREQ_CFG.fb_int_ratio < 21'h0_0008))
    else $error("low flag wrong");
  a_frac_split: assert property (WR_STB && ADDR == FB_FRAC_ADDR + 16'h0001 |=>
    FREQ_CFG.fb_num[9:8] == $past(WDATA[1:0]) && FREQ_CFG.fb_mod[3:0] == $past(WDATA[7:4])) else $error("fraction wrong");
  a_scale_unit: assert property (WR_STB && ADDR == PRIO_ADDR |=> REF_CFG.ph_unit == $past(WDATA[7]))
    else $error("unit wrong");
  a_p2_unit: assert property (FREQ_CFG.ph_unit == P2_PH_SCALE)
    else $error("profile 2 unit wrong");
  a_prio_fields: assert property (WR_STB && ADDR == PRIO_ADDR |=>
    REF_CFG.sel_prio == $past(WDATA[2:0]) && REF_CFG.promo_prio == $past(WDATA[5:3])) else $error("priority wrong");
  a_eff_prio: assert property ($past(RST_B) |->
    REF_CFG.eff_prio == ($past(REF_ACTIVE) ? REF_CFG.promo_prio : REF_CFG.sel_prio)) else $error("active priority wrong");
  a_thr_top: assert property (WR_STB && ADDR == FR_THR_ADDR + 16'h0002 |=>
    FREQ_CFG.fr_thr[23:16] == $past(WDATA)) else $error("threshold wrong");
  a_drain_read: assert property (RD_STB && ADDR == FR_DRAIN_ADDR |=> RDATA == FREQ_CFG.fr_drain)
    else $error("drain readback wrong");
  a_period_top: assert property (WR_STB && ADDR == PERIOD_ADDR + 16'h0004 |=>
    REF_CFG.period_fs[39:32] == $past(WDATA)) else $error("period wrong");
  a_profiles_apart: assert property (WR_STB && ADDR >= PRIO_ADDR |=>
    $stable(FREQ_CFG.fr_thr) && $stable(FREQ_CFG.in_div_ratio)) else $error("other profile disturbed");
endmodule

bind profile_bank profile_bank_assertions u_chk (.REF_CLK(REF_CLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA),
  .WR_STB(WR_STB), .RD_STB(RD_STB), .REF_ACTIVE(REF_ACTIVE), .P2_PH_SCALE(P2_PH_SCALE), .RDATA(RDATA),
  .FREQ_CFG(FREQ_CFG),
  .REF_CFG(REF_CFG), .FB_INT_LOW(FB_INT_LOW));

// ===== tb/profile_bank_test.sv
// Testbench: register port sequences for the profile configuration bank
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin n_fail++; \
  $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module profile_bank_test
  import profile_bank_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [ADDR_W-1:0] addr = 16'h0000;
  logic [DATA_W-1:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic ref_active = 1'b0;
  logic p2_ph_scale = 1'b0;
  logic [DATA_W-1:0] rdata;
  freq_cfg_t freq_cfg;
  ref_cfg_t ref_cfg;
  logic fb_int_low;
  logic [7:0] m [0:27];
  int n_fail = 0;
  int checked = 0;

  always #20 ref_clk = ~ref_clk;

  profile_bank u_dut (.REF_CLK(ref_clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR_STB(wr_stb),
    .RD_STB(rd_stb), .REF_ACTIVE(ref_active), .P2_PH_SCALE(p2_ph_scale), .RDATA(rdata), .FREQ_CFG(freq_cfg),
    .REF_CFG(ref_cfg),
    .FB_INT_LOW(fb_int_low));

  // Bits that read back; unused bits must come back as zero
  function automatic logic [7:0] mask(input int i);
    case (i)
      3, 10: mask = 8'h3f;
      6: mask = 8'h0f;
      7: mask = 8'h00;
      9: mask = 8'hf3;
      20: mask = 8'hbf;
      default: mask = 8'hff;
    endcase
  endfunction

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask

  // Read data is looked at only in its single answer cycle
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1 `CHK("read data", exp, rdata)
  endtask

  task automatic end_of_test();
    if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Bound on the whole run in case a sequence hangs
  initial begin
    #100000;
    n_fail++;
    end_of_test();
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1 `CHK("in div reset", 31'h0000_0001, freq_cfg.in_div_ratio)
    `CHK("fb low reset", 1'b1, fb_int_low)
    // Patterns set some unused bits too, so stray storage shows on readback
    // Pad bytes get zeros, as software must write them
    for (int i = 0; i < 28; i++) begin
      m[i] = (i > 25) ? 8'h00 : ~8'(i * 19);
      wr(16'h069e + 16'(i), m[i]);
      m[i] = m[i] & mask(i);
    end
    wr(16'h069d, 8'hff);
    wr(16'h06ba, 8'hff);
    for (int i = -1; i < 29; i++) rd(16'h069e + 16'(i), (i < 0 || i > 27) ? 8'h00 : m[i]);
    `CHK("in div", (31'({m[3], m[2], m[1], m[0]}) + 31'h0000_0001), freq_cfg.in_div_ratio)
    `CHK("fb int", (21'({m[6][3:0], m[5], m[4]}) + 21'h0_0001), freq_cfg.fb_int_ratio)
    `CHK("fb num", ({m[9][1:0], m[8]}), freq_cfg.fb_num)
    `CHK("fb mod", ({m[10][5:0], m[9][7:4]}), freq_cfg.fb_mod)
    `CHK("ph thr", ({m[12], m[11]}), freq_cfg.ph_thr)
    `CHK("ph fill", m[13], freq_cfg.ph_fill)
    `CHK("ph drain", m[14], freq_cfg.ph_drain)
    `CHK("fr thr", ({m[17], m[16], m[15]}), freq_cfg.fr_thr)
    `CHK("fr fill", m[18], freq_cfg.fr_fill)
    `CHK("fr drain", m[19], freq_cfg.fr_drain)
    `CHK("sel prio", m[20][2:0], ref_cfg.sel_prio)
    `CHK("promo prio", m[20][5:3], ref_cfg.promo_prio)
    `CHK("p2 unit", UNIT_PS, freq_cfg.ph_unit)
    `CHK("period", ({m[25], m[24], m[23], m[22], m[21]}), ref_cfg.period_fs)
    // Least legal integer divider value
    wr(16'h06a2, 8'h07);
    wr(16'h06a3, 8'h00);
    wr(16'h06a4, 8'h00);
    #1 `CHK("fb low", 1'b0, fb_int_low)
    `CHK("fb int 7", 21'h0_0008, freq_cfg.fb_int_ratio)
    // Active reference switches to promoted level one cycle late; promoted is never above selected
    wr(PRIO_ADDR, 8'h93);
    #1 `CHK("unit ns", UNIT_NS, ref_cfg.ph_unit)
    `CHK("p2 unit kept", UNIT_PS, freq_cfg.ph_unit)
    @(posedge ref_clk) ref_active <= 1'b1;
    p2_ph_scale <= 1'b1;
    @(posedge ref_clk);
    #1 `CHK("promoted", 3'h2, ref_cfg.eff_prio)
    `CHK("p2 unit ns", UNIT_NS, freq_cfg.ph_unit)
    wr(PRIO_ADDR, 8'h0c);
    #1 `CHK("unit ps", UNIT_PS, ref_cfg.ph_unit)
    `CHK("p2 unit held", UNIT_NS, freq_cfg.ph_unit)
    `CHK("promoted 1", 3'h1, ref_cfg.eff_prio)
    @(posedge ref_clk) ref_active <= 1'b0;
    @(posedge ref_clk);
    #1 `CHK("selected", 3'h4, ref_cfg.eff_prio)
    end_of_test();
  end
endmodule
